// File: rtl/mcad_pkg.sv
`default_nettype none
package mcad_pkg;
  // =====================================================
  // address map (20-bit processor bus)
  localparam logic [19:0] MCAD_ROM5_BASE = 20'hF8000;
  localparam logic [19:0] MCAD_ROM5_LAST = 20'hFFFFF;
  localparam logic [19:0] MCAD_ROM4_BASE = 20'hF0000;
  localparam logic [19:0] MCAD_ROM4_LAST = 20'hF7FFF;
  localparam logic [19:0] MCAD_ROM3_BASE = 20'hE8000;
  localparam logic [19:0] MCAD_ROM3_LAST = 20'hEFFFF;
  localparam logic [19:0] MCAD_ROM2_BASE = 20'hE0000;
  localparam logic [19:0] MCAD_ROM2_LAST = 20'hE7FFF;
  localparam logic [19:0] MCAD_ROM1_BASE = 20'hB0C00;
  localparam logic [19:0] MCAD_ROM1_LAST = 20'hB7FFF;
  localparam logic [19:0] MCAD_LED_BASE = 20'hB8000;
  localparam logic [19:0] MCAD_LED_LAST = 20'hBBFFF;
  localparam logic [19:0] MCAD_CMOS_BASE = 20'hBC000;
  localparam logic [19:0] MCAD_CMOS_LAST = 20'hBFFFF;
  localparam logic [19:0] MCAD_SLOT1_BASE = 20'h90000;
  localparam logic [19:0] MCAD_SLOT1_LAST = 20'h9FFFF;
  localparam logic [19:0] MCAD_SLOT2_BASE = 20'hA0000;
  localparam logic [19:0] MCAD_SLOT2_LAST = 20'hAFFFF;
  localparam logic [19:0] MCAD_DRAM_BASE = 20'h00000;
  localparam logic [19:0] MCAD_DRAM_FULL_LAST = 20'h3FFFF;
  localparam logic [19:0] MCAD_DRAM_HALF_LAST = 20'h1FFFF;
  // =====================================================
  // widths and reset values
  localparam int MCAD_ADDR_W = 20;
  localparam int MCAD_ROM_N = 5;
  localparam logic [4:0] MCAD_ROM_SEL_IDLE = 5'h1F;
  localparam logic [3:0] MCAD_DRAM_SEL_IDLE = 4'hF;
  localparam logic [5:0] MCAD_LED_RST = 6'h00;
  localparam logic [2:0] MCAD_HOLD_HOLD_CYC = 3'h4;
endpackage : mcad_pkg
`default_nettype wire

// File: rtl/mcad_sync.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// two flop level synchroniser
module mcad_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end
  assign dout = sync_ff;
endmodule : mcad_sync
`default_nettype wire

// File: rtl/mcad_top.sv
`timescale 1ns/100ps
`default_nettype none
module mcad_top
  import mcad_pkg::*;
#(
  parameter int ADDR_W = mcad_pkg::MCAD_ADDR_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // processor bus
  input wire logic [ADDR_W-1:0] latched_address_lines,
  input wire logic io_not_memory_indicator,
  input wire logic buffered_read_strobe_n,
  input wire logic buffered_write_strobe_n,
  input wire logic address_qualify,
  input wire logic transmit_receive_direction,
  input wire logic data_enable_buffered,
  input wire logic [7:0] bus_data_in,
  // board control inputs
  input wire logic ram_write_inhibit,
  input wire logic ram_size_strap,
  input wire logic power_fail_warning_n,
  input wire logic synced_hold_acknowledge,
  input wire logic hold_needed,
  // ROM and slot selects
  output logic [4:0] rom_select_n,
  output logic accessory_one_select_n,
  output logic accessory_two_select_n,
  output logic rom_cycle_indicator,
  // transceiver
  output logic transceiver_control,
  output logic transceiver_to_bus,
  // dram
  output logic [3:0] dram_bank_select_n,
  output logic dram_write_enable_n,
  // cmos ram
  output logic cmos_select_n,
  output logic cmos_output_enable_n,
  output logic cmos_write_strobe_n,
  output logic cmos_standby,
  // status leds and hold
  output logic [5:0] led_drive_n,
  output logic card_hold_request,
  output logic hold_granted
);
  import mcad_pkg::*;

  // =====================================================
  // input synchronisation
  localparam int SYNC_W = 10;
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] syn_in;
  logic [ADDR_W-1:0] addr_s;
  logic io_s;
  logic rd_n_s;
  logic wr_n_s;
  logic go_s;
  logic dir_s;
  logic den_s;
  logic inhibit_s;
  logic strap_s;
  logic pfail_n_s;
  logic hold_need_s;
  // active low inputs enter inverted so the reset value reads as idle
  assign raw_in = {io_not_memory_indicator, !buffered_read_strobe_n,
                   !buffered_write_strobe_n, address_qualify,
                   transmit_receive_direction, data_enable_buffered,
                   ram_write_inhibit, ram_size_strap, !power_fail_warning_n,
                   hold_needed};
  mcad_sync #(.W(SYNC_W)) u_sync (
    .clk(clk),
    .rst(rst),
    .din(raw_in),
    .dout(syn_in)
  );

  logic [ADDR_W-1:0] addr_m_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [7:0] data_m_ff;
  logic [7:0] data_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_m_ff <= '0;
      addr_ff <= '0;
      data_m_ff <= 8'h00;
      data_ff <= 8'h00;
    end else begin
      addr_m_ff <= latched_address_lines;
      addr_ff <= addr_m_ff;
      data_m_ff <= bus_data_in;
      data_ff <= data_m_ff;
    end
  end

  assign addr_s = addr_ff;
  assign io_s = syn_in[9];
  assign rd_n_s = !syn_in[8];
  assign wr_n_s = !syn_in[7];
  assign go_s = syn_in[6];
  assign dir_s = syn_in[5];
  assign den_s = syn_in[4];
  assign inhibit_s = syn_in[3];
  assign strap_s = syn_in[2];
  assign pfail_n_s = !syn_in[1];
  assign hold_need_s = syn_in[0];

  // =====================================================
  // decode helpers
  function automatic logic in_range(input logic [19:0] a,
                                    input logic [19:0] lo,
                                    input logic [19:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range
  logic mem_cyc;
  logic [4:0] rom_hit;
  logic led_hit;
  logic cmos_hit;
  logic dram_hit;
  logic slot1_hit;
  logic slot2_hit;
  logic [19:0] a20;
  logic [4:0] top5;
  assign a20 = addr_s[19:0];
  assign top5 = a20[19:15];
  assign mem_cyc = !io_s && !rst;
  // roms 2-5 decode from the top five address lines only
  assign rom_hit[4] = mem_cyc && (top5 == MCAD_ROM5_BASE[19:15]);
  assign rom_hit[3] = mem_cyc && (top5 == MCAD_ROM4_BASE[19:15]);
  assign rom_hit[2] = mem_cyc && (top5 == MCAD_ROM3_BASE[19:15]);
  assign rom_hit[1] = mem_cyc && (top5 == MCAD_ROM2_BASE[19:15]);
  assign rom_hit[0] = mem_cyc &&
                      in_range(a20, MCAD_ROM1_BASE, MCAD_ROM1_LAST);
  assign led_hit = mem_cyc && in_range(a20, MCAD_LED_BASE, MCAD_LED_LAST);
  assign cmos_hit = mem_cyc && in_range(a20, MCAD_CMOS_BASE, MCAD_CMOS_LAST);
  // 128K fit maps only the lower two banks
  assign dram_hit = mem_cyc && in_range(a20, MCAD_DRAM_BASE, strap_s ?
                    MCAD_DRAM_FULL_LAST : MCAD_DRAM_HALF_LAST);
  assign slot1_hit = mem_cyc &&
                     in_range(a20, MCAD_SLOT1_BASE, MCAD_SLOT1_LAST);
  assign slot2_hit = mem_cyc &&
                     in_range(a20, MCAD_SLOT2_BASE, MCAD_SLOT2_LAST);

  // =====================================================
  // rom and slot selects
  logic [4:0] rom_sel_n_ff;
  logic slot1_n_ff;
  logic slot2_n_ff;
  logic rom_ind_ff;
  logic any_rom;
  assign any_rom = |rom_hit;

  always_ff @(posedge clk) begin
    if (rst) begin
      rom_sel_n_ff <= MCAD_ROM_SEL_IDLE;
      rom_ind_ff <= 1'b0;
    end else begin
      rom_sel_n_ff <= ~(rom_hit & {MCAD_ROM_N{!rd_n_s && go_s}});
      // indicator follows address so the wait logic sees it before T3
      rom_ind_ff <= any_rom;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      slot1_n_ff <= 1'b1;
      slot2_n_ff <= 1'b1;
    end else begin
      slot1_n_ff <= !slot1_hit;
      slot2_n_ff <= !slot2_hit;
    end
  end

  // =====================================================
  // transceiver
  logic xcvr_ff;
  logic dir_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      xcvr_ff <= 1'b0;
      dir_ff <= 1'b0;
    end else begin
      xcvr_ff <= den_s &&
                 (any_rom || cmos_hit || dram_hit || led_hit);
      dir_ff <= !dir_s;
    end
  end

  // =====================================================
  // dynamic ram
  logic [3:0] bank_n_ff;
  logic dram_we_n_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      bank_n_ff <= MCAD_DRAM_SEL_IDLE;
      dram_we_n_ff <= 1'b1;
    end else begin
      bank_n_ff <= MCAD_DRAM_SEL_IDLE;
      if (dram_hit && go_s) begin
        bank_n_ff[a20[17:16]] <= 1'b0;
      end
      dram_we_n_ff <= !(dram_hit && go_s && !wr_n_s && !inhibit_s);
    end
  end

  // =====================================================
  // cmos ram
  logic cmos_sel_n_ff;
  logic cmos_oe_n_ff;
  logic cmos_wr_n_ff;
  logic standby_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      cmos_sel_n_ff <= 1'b1;
      cmos_oe_n_ff <= 1'b1;
      cmos_wr_n_ff <= 1'b1;
      standby_ff <= 1'b0;
    end else begin
      standby_ff <= !pfail_n_s;
      // standby forces the part deselected
      cmos_sel_n_ff <= !(cmos_hit && go_s && pfail_n_s);
      cmos_oe_n_ff <= !(cmos_hit && go_s && pfail_n_s && !rd_n_s);
      cmos_wr_n_ff <= !(cmos_hit && go_s && pfail_n_s && !wr_n_s);
    end
  end

  // =====================================================
  // status leds: clocked when the qualify strobe falls
  logic [5:0] led_ff;
  logic go_d_ff;
  logic led_wr_pend_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      led_ff <= MCAD_LED_RST;
      go_d_ff <= 1'b0;
      led_wr_pend_ff <= 1'b0;
    end else begin
      go_d_ff <= go_s;
      if (go_s && led_hit && !wr_n_s) begin
        led_wr_pend_ff <= 1'b1;
      end else if (!go_s && go_d_ff) begin
        led_wr_pend_ff <= 1'b0;
      end
      if (!go_s && go_d_ff && led_wr_pend_ff) begin
        led_ff <= data_ff[5:0];
      end
    end
  end

  // =====================================================
  // hold request and grant
  logic hold_req_ff;
  logic granted_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_req_ff <= 1'b0;
      granted_ff <= 1'b0;
    end else begin
      hold_req_ff <= hold_need_s;
      // acknowledge already on the bus clock, no resync
      granted_ff <= hold_req_ff && synced_hold_acknowledge;
    end
  end

  // =====================================================
  // outputs
  assign rom_select_n = rom_sel_n_ff;
  assign accessory_one_select_n = slot1_n_ff;
  assign accessory_two_select_n = slot2_n_ff;
  assign rom_cycle_indicator = rom_ind_ff;
  assign transceiver_control = xcvr_ff;
  assign transceiver_to_bus = dir_ff;
  assign dram_bank_select_n = bank_n_ff;
  assign dram_write_enable_n = dram_we_n_ff;
  assign cmos_select_n = cmos_sel_n_ff;
  assign cmos_output_enable_n = cmos_oe_n_ff;
  assign cmos_write_strobe_n = cmos_wr_n_ff;
  assign cmos_standby = standby_ff;
  assign led_drive_n = led_ff;
  assign card_hold_request = hold_req_ff;
  assign hold_granted = granted_ff;
  // =====================================================
  // checks
  sequence s_rom_read;
    !io_s && !rd_n_s && go_s && any_rom;
  endsequence
  a_rom_select_read: assert property (@(posedge clk) disable iff (rst)
    s_rom_read |=> (rom_sel_n_ff != MCAD_ROM_SEL_IDLE))
    else $error("rom read did not select a rom");
  a_rom_idle_io: assert property (@(posedge clk) disable iff (rst)
    $past(io_s) |-> (rom_sel_n_ff == MCAD_ROM_SEL_IDLE) && slot1_n_ff
      && slot2_n_ff)
    else $error("select active in io cycle");
  a_rom_onehot: assert property (@(posedge clk) disable iff (rst)
    $onehot0(~rom_sel_n_ff))
    else $error("more than one rom selected");
  a_rom_top_map: assert property (@(posedge clk) disable iff (rst)
    (s_rom_read and (a20[19:15] == 5'h1F)) |=> !rom_sel_n_ff[4])
    else $error("top rom not selected");
  a_slot_one_map: assert property (@(posedge clk) disable iff (rst)
    (mem_cyc && a20[19:16] == 4'h9) |=> !slot1_n_ff && slot2_n_ff)
    else $error("slot one select wrong");
  a_xcvr_idle: assert property (@(posedge clk) disable iff (rst)
    (!any_rom && !cmos_hit && !dram_hit && !led_hit) |=> !xcvr_ff)
    else $error("transceiver on without target");
  a_rom_indicator: assert property (@(posedge clk) disable iff (rst)
    any_rom |=> rom_ind_ff)
    else $error("rom indicator missing");
  a_dram_inhibit: assert property (@(posedge clk) disable iff (rst)
    inhibit_s |=> dram_we_n_ff)
    else $error("dram write while inhibited");
  a_cmos_standby: assert property (@(posedge clk) disable iff (rst)
    !pfail_n_s |=> standby_ff && cmos_sel_n_ff)
    else $error("cmos not in standby on power fail");
  a_hold_follow: assert property (@(posedge clk) disable iff (rst)
    hold_need_s |=> hold_req_ff)
    else $error("hold request not raised");
endmodule : mcad_top
`default_nettype wire

// File: test/mcad_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// processor bus and wait-state logic seen from the card
module mcad_bus_model #(
  parameter int TS = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus toward the card
  output logic [19:0] addr,
  output logic io,
  output logic rd_n,
  output logic wr_n,
  output logic qual,
  output logic dir,
  output logic den,
  output logic [7:0] data,
  output logic hold_ack,
  // answers from the card
  input wire logic rom_ind,
  input wire logic cmos_sel_n,
  input wire logic hold_req
);
  initial begin
    addr = 20'h00000;
    io = 1'b1;
    {rd_n, wr_n, qual, dir, den} = 5'h18;
    data = 8'h00;
    hold_ack = 1'b0;
  end
  always @(negedge clk) hold_ack <= rst ? 1'b0 : hold_req;
  task automatic tstate();
    repeat (TS) @(negedge clk);
  endtask : tstate
  // t1 to the end of t3; the caller samples the card here
  task automatic first_half(input logic [19:0] a, input logic i,
                            input logic w, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    io = i;
    dir = w;
    data = ~d;
    tstate();
    qual = 1'b1;
    den = 1'b1;
    rd_n = w;
    wr_n = !w;
    data = d;
    tstate();
    tstate();
  endtask : first_half
  // wait states, then t4
  task automatic second_half();
    int nw;
    nw = rom_ind ? 0 : 1;
    if (!cmos_sel_n) nw = 6;
    repeat (nw * TS) @(negedge clk);
    qual = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    den = 1'b0;
    tstate();
    data = ~data;
  endtask : second_half
endmodule : mcad_bus_model
`default_nettype wire

// File: test/mcad_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module mcad_tb_top;
  import mcad_pkg::*;
  // =====================================================
  // clock, board inputs and wiring
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strap = 1'b1;
  logic inhibit = 1'b0;
  logic pwr_n = 1'b1;
  logic hold_need = 1'b0;
  logic [19:0] addr;
  logic [7:0] data;
  logic io, rd_n, wr_n, qual, dir, den, ack;
  logic [4:0] rom_sel_n;
  logic [5:0] led_n;
  logic slot1_n, slot2_n, rom_ind, xcvr, dram_we_n, cmos_sel_n;
  logic standby, hold_req, granted;
  logic to_bus, cmos_oe_n, cmos_wr_n;
  logic [3:0] bank_n;
  int n_fail = 0;
  int n_compared = 0;
  logic [19:0] corners [] = '{20'hF8000, 20'hFFFFF, 20'hF7FFF, 20'hF0000,
    20'hE8000, 20'hE7FFF, 20'hE0000, 20'hDFFFF, 20'hB0C00, 20'hB0BFF,
    20'hB7FFF, 20'h90000, 20'h9FFFF, 20'h8FFFF, 20'hA0000, 20'hAFFFF,
    20'hB8000, 20'hBC000, 20'h00000, 20'h3FFFF, 20'h20000};
  always #4 clk = ~clk;
  mcad_top i_mcad_top (.clk(clk), .rst(rst), .latched_address_lines(addr),
    .io_not_memory_indicator(io), .buffered_read_strobe_n(rd_n),
    .buffered_write_strobe_n(wr_n), .address_qualify(qual),
    .transmit_receive_direction(dir), .data_enable_buffered(den),
    .bus_data_in(data), .ram_write_inhibit(inhibit),
    .ram_size_strap(strap), .power_fail_warning_n(pwr_n),
    .synced_hold_acknowledge(ack), .hold_needed(hold_need),
    .rom_select_n(rom_sel_n), .accessory_one_select_n(slot1_n),
    .accessory_two_select_n(slot2_n), .rom_cycle_indicator(rom_ind),
    .transceiver_control(xcvr), .transceiver_to_bus(to_bus),
    .dram_bank_select_n(bank_n), .dram_write_enable_n(dram_we_n),
    .cmos_select_n(cmos_sel_n), .cmos_output_enable_n(cmos_oe_n),
    .cmos_write_strobe_n(cmos_wr_n), .cmos_standby(standby),
    .led_drive_n(led_n),
    .card_hold_request(hold_req), .hold_granted(granted));
  mcad_bus_model i_mcad_bus_model (.clk(clk), .rst(rst), .addr(addr),
    .io(io), .rd_n(rd_n), .wr_n(wr_n), .qual(qual), .dir(dir), .den(den),
    .data(data), .hold_ack(ack), .rom_ind(rom_ind),
    .cmos_sel_n(cmos_sel_n), .hold_req(hold_req));
  // =====================================================
  // expectations and checking
  function automatic logic inr(input logic [19:0] a, lo, hi);
    return a >= lo && a <= hi;
  endfunction : inr
  function automatic logic [4:0] exp_rom(input logic [19:0] a,
                                         input logic r);
    if (!r) return 5'h1F;
    if (inr(a, MCAD_ROM5_BASE, MCAD_ROM5_LAST)) return 5'h0F;
    if (inr(a, MCAD_ROM4_BASE, MCAD_ROM4_LAST)) return 5'h17;
    if (inr(a, MCAD_ROM3_BASE, MCAD_ROM3_LAST)) return 5'h1B;
    if (inr(a, MCAD_ROM2_BASE, MCAD_ROM2_LAST)) return 5'h1D;
    if (inr(a, MCAD_ROM1_BASE, MCAD_ROM1_LAST)) return 5'h1E;
    return 5'h1F;
  endfunction : exp_rom
  function automatic logic dram_hit(input logic [19:0] a);
    return inr(a, 20'h00000, strap ? 20'h3FFFF : 20'h1FFFF);
  endfunction : dram_hit
  function automatic logic card_hit(input logic [19:0] a);
    return exp_rom(a, 1'b1) != 5'h1F || dram_hit(a) ||
      inr(a, MCAD_LED_BASE, MCAD_LED_LAST) ||
      inr(a, MCAD_CMOS_BASE, MCAD_CMOS_LAST);
  endfunction : card_hit
  task automatic chk(input string nm, input logic [19:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic access(input logic [19:0] a, input logic i, w,
                        input logic [7:0] d);
    logic m;
    logic cm;
    logic [3:0] eb;
    m = !i;
    cm = m && pwr_n && inr(a, MCAD_CMOS_BASE, MCAD_CMOS_LAST);
    eb = (m && dram_hit(a)) ? ~(4'h1 << a[17:16]) : 4'hF;
    i_mcad_bus_model.first_half(a, i, w, d);
    chk("rom_select_n", rom_sel_n, exp_rom(a, m && !w));
    chk("slot one", slot1_n, !(m && inr(a, 20'h90000, 20'h9FFFF)));
    chk("slot two", slot2_n, !(m && inr(a, 20'hA0000, 20'hAFFFF)));
    chk("cmos_select_n", cmos_sel_n, !cm);
    chk("cmos_oe_n", cmos_oe_n, !(cm && !w));
    chk("cmos_wr_n", cmos_wr_n, !(cm && w));
    chk("dram_write_n", dram_we_n,
        !(m && w && dram_hit(a) && !inhibit));
    chk("bank_n", bank_n, eb);
    chk("to_bus", to_bus, !w);
    chk("rom cycle", rom_ind, exp_rom(a, m) != 5'h1F);
    chk("transceiver", xcvr, m && card_hit(a));
    i_mcad_bus_model.second_half();
  endtask : access
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // =====================================================
  // main sequence
  initial begin
    logic [19:0] a;
    void'($urandom(20));
    repeat (4) @(negedge clk);
    chk("reset rom", rom_sel_n, 5'h1F);
    chk("reset slots", {slot1_n, slot2_n, rom_ind}, 3'h6);
    chk("reset leds", led_n, 6'h00);
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    foreach (corners[k]) for (int i = 0; i < 2; i++) begin
      access(corners[k], i[0], 1'b0, 8'h00);
    end
    access(MCAD_LED_BASE, 1'b0, 1'b1, 8'h2A);
    repeat (8) @(negedge clk);
    chk("led", led_n, 6'h2A);
    access(20'h000C4, 1'b1, 1'b1, 8'h3C);
    access(20'h000FF, 1'b1, 1'b0, 8'h00);
    repeat (80) begin
      a = $urandom_range(0, 1) ? $urandom_range(0, 20'hFFFFF) :
        corners[$urandom_range(0, corners.size() - 1)] ^ $urandom_range(0, 15);
      strap = $urandom_range(0, 1);
      inhibit = $urandom_range(0, 1);
      access(a, $urandom_range(0, 3) == 0, $urandom_range(0, 1),
             8'($urandom));
    end
    pwr_n = 1'b0;
    repeat (8) @(negedge clk);
    chk("standby", standby, 1'b1);
    access(MCAD_CMOS_BASE, 1'b0, 1'b0, 8'h00);
    pwr_n = 1'b1;
    repeat (8) @(negedge clk);
    chk("standby off", standby, 1'b0);
    access(MCAD_CMOS_BASE, 1'b0, 1'b1, 8'h05);
    hold_need = 1'b1;
    repeat (10) @(negedge clk);
    chk("hold", {hold_req, granted}, 2'h3);
    hold_need = 1'b0;
    repeat (10) @(negedge clk);
    chk("hold off", {hold_req, granted}, 2'h0);
    final_report();
  end
  initial begin
    repeat (50000) @(posedge clk);
    n_fail++;
    final_report();
  end
endmodule : mcad_tb_top
`default_nettype wire
